// ---- verilog/eto_pkg.sv ----
package eto_pkg;
  // ------------------------------------------------------------
  // widths and timing
  // ------------------------------------------------------------
  localparam int ETO_LINES       = 32;
  localparam int ETO_OUT_LO      = 16;
  localparam int ETO_STATIC_N    = 8;
  localparam int ETO_EVENT_N     = 5;
  localparam int ETO_DELAY_CYC   = 8;
  localparam int ETO_PIPE_W      = 8;

  // ------------------------------------------------------------
  // line positions on the cable
  // ------------------------------------------------------------
  localparam int ETO_POS_STATIC  = 24;
  localparam int ETO_POS_BREAK   = 23;
  localparam int ETO_POS_TRACE   = 22;
  localparam int ETO_POS_FILTER  = 21;
  localparam int ETO_POS_EVENT   = 16;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] ETO_OFF_STAGE  = 12'h000;
  localparam logic [11:0] ETO_OFF_COMMIT = 12'h004;
  localparam logic [11:0] ETO_OFF_LEVEL  = 12'h008;
  localparam logic [11:0] ETO_OFF_STATUS = 12'h00c;
  localparam logic [11:0] ETO_OFF_SEL    = 12'h010;

  // ------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------
  localparam int ETO_SEL_W       = 4;
  localparam logic [15:0] ETO_STAGE_RST = 16'h0000;
  localparam logic [7:0]  ETO_LEVEL_RST = 8'h00;
  localparam logic [19:0] ETO_SEL_RST   = 20'h43210;

  // per-line staged command, two bits each
  typedef enum logic [1:0] {
    ETO_CMD_KEEP = 2'h0,
    ETO_CMD_LOW  = 2'h1,
    ETO_CMD_HIGH = 2'h2
  } eto_cmd_t;
endpackage

// ---- verilog/eto_line_if.sv ----
`timescale 1ns/1ps
// carries the static-line staging between top and bank
interface eto_line_if;
  logic [15:0] stage;
  logic        commit;
  logic [7:0]  level;
  modport ctrl (output stage, output commit, input level);
  modport bank (input stage, input commit, output level);
endinterface

// ---- verilog/eto_static_bank.sv ----
`timescale 1ns/1ps
module eto_static_bank
  import eto_pkg::*;
#(
  parameter int N = ETO_STATIC_N
) (
  input  wire logic clock,
  input  wire logic rst,
  eto_line_if.bank  lines
);

  logic [7:0] level_r;
  logic [7:0] level_nxt;

  // ------------------------------------------------------------
  // commit: every line updated together, keep holds old level
  // ------------------------------------------------------------
  always_comb begin
    level_nxt = level_r;
    if (lines.commit) begin
      for (int i = 0; i < N; i++) begin
        case (eto_cmd_t'(lines.stage[2*i +: 2]))
          ETO_CMD_LOW:  level_nxt[i] = 1'b0;
          ETO_CMD_HIGH: level_nxt[i] = 1'b1;
          default:      level_nxt[i] = level_r[i];
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level_r <= ETO_LEVEL_RST;
    end else begin
      level_r <= level_nxt;
    end
  end

  assign lines.level = level_r;
endmodule

// ---- verilog/eto_trigger_out.sv ----
`timescale 1ns/1ps
// What this block does
// - drive only cable lines 31 to 16
// - lines 31-24 hold host-chosen static levels
// - static levels readable back by host
// - each static line: low, high or keep
// - staged levels apply together on commit
// - status lines 23-21 always enabled
// - breakpoint line latches high after hit
// - trace-point line high only during hits
// - filter line high only while filtering
// - five event lines follow selected events
// - event outputs lag detection eight cycles
module eto_trigger_out
  import eto_pkg::*;
#(
  parameter int DELAY  = ETO_DELAY_CYC,
  parameter int EVT_N  = 16
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 break_hit,
  input  wire logic                 trace_hit,
  input  wire logic                 filter_act,
  input  wire logic                 prog_restart,
  input  wire logic [EVT_N-1:0]     event_det,
  output logic      [31:0]          external_trigger_line_o,
  output logic      [31:0]          external_trigger_line_oe
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  eto_line_if lines ();

  logic [15:0]           stage_r;
  logic [15:0]           stage_nxt;
  logic                  commit_r;
  logic                  commit_nxt;
  logic [19:0]           sel_r;
  logic [19:0]           sel_nxt;
  logic                  brk_r;
  logic                  brk_nxt;
  logic                  trc_r;
  logic                  trc_nxt;
  logic                  flt_r;
  logic                  flt_nxt;
  logic [31:0]           rdata_r;
  logic [31:0]           rdata_nxt;
  logic                  err_r;
  logic                  err_nxt;
  logic [ETO_EVENT_N-1:0] pipe_r   [DELAY];
  logic [ETO_EVENT_N-1:0] pipe_nxt [DELAY];
  logic [ETO_EVENT_N-1:0] evt_pick;
  logic                  setup_en;
  logic                  wr_en;
  logic                  rd_en;

  // ------------------------------------------------------------
  // static bank
  // ------------------------------------------------------------
  eto_static_bank #(
    .N     (ETO_STATIC_N)
  ) u_bank (
    .clock (clock),
    .rst   (rst),
    .lines (lines.bank)
  );

  assign lines.stage  = stage_r;
  assign lines.commit = commit_r;

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  // zero wait states: access phase always completes on first edge
  assign pready  = 1'b1;
  assign pslverr = err_r;
  assign prdata  = rdata_r;
  // writes land on the access edge, the only edge the master commits to
  assign setup_en = psel & ~penable;
  assign wr_en    = psel & penable & pwrite;
  assign rd_en    = psel & ~penable & ~pwrite;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == ETO_OFF_STAGE) || (a == ETO_OFF_COMMIT) ||
             (a == ETO_OFF_LEVEL) || (a == ETO_OFF_STATUS) ||
             (a == ETO_OFF_SEL);
  endfunction

  // read data and error decoded in setup so they stand in access
  always_comb begin
    stage_nxt  = stage_r;
    commit_nxt = 1'b0;
    sel_nxt    = sel_r;
    rdata_nxt  = rdata_r;
    err_nxt    = 1'b0;
    if (setup_en) begin
      err_nxt = ~mapped(paddr);
    end
    if (wr_en) begin
      if (paddr == ETO_OFF_STAGE) begin
        stage_nxt = pwdata[15:0];
      end else if (paddr == ETO_OFF_COMMIT) begin
        commit_nxt = pwdata[0];
      end else if (paddr == ETO_OFF_SEL) begin
        sel_nxt = pwdata[19:0];
      end
    end else if (rd_en) begin
      rdata_nxt = 32'h0000_0000;
      if (paddr == ETO_OFF_STAGE) begin
        rdata_nxt = {16'h0000, stage_r};
      end else if (paddr == ETO_OFF_LEVEL) begin
        rdata_nxt = {24'h000000, lines.level};
      end else if (paddr == ETO_OFF_STATUS) begin
        rdata_nxt = {29'h0, brk_r, trc_r, flt_r};
      end else if (paddr == ETO_OFF_SEL) begin
        rdata_nxt = {12'h000, sel_r};
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage_r  <= ETO_STAGE_RST;
      commit_r <= 1'b0;
      sel_r    <= ETO_SEL_RST;
      rdata_r  <= 32'h0000_0000;
      err_r    <= 1'b0;
    end else begin
      stage_r  <= stage_nxt;
      commit_r <= commit_nxt;
      sel_r    <= sel_nxt;
      rdata_r  <= rdata_nxt;
      err_r    <= err_nxt;
    end
  end

  // ------------------------------------------------------------
  // status lines
  // ------------------------------------------------------------
  // a hit in the restart cycle wins, so that break is not lost
  always_comb begin
    brk_nxt = brk_r;
    if (prog_restart) begin
      brk_nxt = 1'b0;
    end
    if (break_hit) begin
      brk_nxt = 1'b1;
    end
    trc_nxt = trace_hit;
    flt_nxt = filter_act;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      brk_r <= 1'b0;
      trc_r <= 1'b0;
      flt_r <= 1'b0;
    end else begin
      brk_r <= brk_nxt;
      trc_r <= trc_nxt;
      flt_r <= flt_nxt;
    end
  end

  // ------------------------------------------------------------
  // event selection and delay pipe
  // ------------------------------------------------------------
  // selector picks the event in the first stage; the pipe adds rest
  always_comb begin
    for (int i = 0; i < ETO_EVENT_N; i++) begin
      evt_pick[i] = event_det[sel_r[ETO_SEL_W*i +: ETO_SEL_W]];
    end
    pipe_nxt[0] = evt_pick;
    for (int s = 1; s < DELAY; s++) begin
      pipe_nxt[s] = pipe_r[s-1];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < DELAY; s++) begin
        pipe_r[s] <= '0;
      end
    end else begin
      for (int s = 0; s < DELAY; s++) begin
        pipe_r[s] <= pipe_nxt[s];
      end
    end
  end

  // ------------------------------------------------------------
  // cable drive
  // ------------------------------------------------------------
  // lower half stays undriven: it belongs to the input side
  assign external_trigger_line_oe = {16'hffff, 16'h0000};
  assign external_trigger_line_o  = {lines.level,
                                     brk_r, trc_r, flt_r,
                                     pipe_r[DELAY-1],
                                     16'h0000};
endmodule

// ---- verif/eto_trigger_out_properties.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module eto_props
  import eto_pkg::*;
#(
  parameter int EVT_N = 16
) (
  input wire logic             clock,
  input wire logic             rst,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic             break_hit,
  input wire logic             trace_hit,
  input wire logic             filter_act,
  input wire logic             prog_restart,
  input wire logic [EVT_N-1:0] event_det,
  input wire logic [31:0]      external_trigger_line_o,
  input wire logic [31:0]      external_trigger_line_oe
);
  logic [31:0] o;
  logic        cm;
  assign o = external_trigger_line_o;
  // commit lands on the access edge of the write
  assign cm = psel && penable && pwrite && paddr == ETO_OFF_COMMIT
              && pwdata[0];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_oe; external_trigger_line_oe == 32'hffff0000; endproperty
  a_oe: assert property (p_oe) else $error("enable mask wrong");
  property p_low; o[15:0] == 16'h0000; endproperty
  a_low: assert property (p_low) else $error("lower lines driven");
  property p_trace; o[22] == $past(trace_hit); endproperty
  a_trace: assert property (p_trace) else $error("trace line");
  property p_filter; o[21] == $past(filter_act); endproperty
  a_filter: assert property (p_filter) else $error("filter line");
  property p_bset; break_hit |=> o[23]; endproperty
  a_bset: assert property (p_bset) else $error("break not set");
  property p_bhold; o[23] && !prog_restart |=> o[23]; endproperty
  a_bhold: assert property (p_bhold) else $error("break dropped");
  property p_bclr; prog_restart && !break_hit |=> !o[23]; endproperty
  a_bclr: assert property (p_bclr) else $error("break kept");
  // line 0 keeps its reset selection throughout the bench
  property p_evt; o[16] == $past(event_det[0], 8); endproperty
  a_evt: assert property (p_evt) else $error("event lag");
  property p_stat; $changed(o[31:24]) |-> $past(cm, 2); endproperty
  a_stat: assert property (p_stat) else $error("static moved");
endmodule

bind eto_trigger_out eto_props #(.EVT_N(EVT_N)) u_props (.clock, .rst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .break_hit, .trace_hit,
  .filter_act, .prog_restart, .event_det, .external_trigger_line_o,
  .external_trigger_line_oe);

// ---- verif/eto_scope.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// far-side instrument: pull-downs on every undriven line
// ------------------------------------------------------------
module eto_scope (
  input  wire logic [31:0] line_o,
  input  wire logic [31:0] line_oe,
  output logic      [31:0] seen
);
  assign seen = line_o & line_oe;
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module tb_top
  import eto_pkg::*;
;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, er;
  logic        break_hit, trace_hit, filter_act, prog_restart;
  logic [11:0] paddr;
  logic [15:0] event_det;
  logic [31:0] pwdata, prdata, rd, seen, line_o, line_oe;
  int          num_errors, n_checks, n;
  int          cyc = 0;

  eto_trigger_out u_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .break_hit, .trace_hit,
    .filter_act, .prog_restart, .event_det,
    .external_trigger_line_o(line_o), .external_trigger_line_oe(line_oe));
  eto_scope u_scope (.line_o, .line_oe, .seen);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // a hang ends the run as a failure
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      close_out;
    end
  end

  task close_out;
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task t_static;
    apb(1'b1, ETO_OFF_STAGE, 32'h00006666);
    @(negedge clock);
    chk(seen, 32'h0);
    apb(1'b1, ETO_OFF_COMMIT, 32'h1);
    repeat (2) @(negedge clock);
    chk(seen, 32'h55000000);
    apb(1'b1, ETO_OFF_STAGE, 32'h0000c008);
    apb(1'b1, ETO_OFF_COMMIT, 32'h1);
    apb(1'b0, ETO_OFF_LEVEL, 32'h0);
    chk(rd, 32'h57);
    chk(er, 32'h0);
    apb(1'b1, 12'h0ff, 32'hffffffff);
    chk(er, 32'h1);
    apb(1'b0, 12'h0ff, 32'h0);
    chk(rd, 32'h0);
    chk(er, 32'h1);
  endtask

  task t_status;
    @(posedge clock) break_hit <= 1'b1;
    @(posedge clock) break_hit <= 1'b0;
    trace_hit <= 1'b1;
    filter_act <= 1'b1;
    repeat (2) @(negedge clock);
    chk(seen[23:16], 8'he0);
    @(posedge clock) trace_hit <= 1'b0;
    filter_act <= 1'b0;
    repeat (4) @(negedge clock);
    chk(seen[23:16], 8'h80);
    apb(1'b0, ETO_OFF_STATUS, 32'h0);
    chk(rd, 32'h4);
    @(posedge clock) prog_restart <= 1'b1;
    @(posedge clock) prog_restart <= 1'b0;
    @(negedge clock);
    chk(seen[23:16], 8'h00);
    @(posedge clock) break_hit <= 1'b1;
    @(posedge clock) prog_restart <= 1'b1;
    @(posedge clock) break_hit <= 1'b0;
    prog_restart <= 1'b0;
    @(negedge clock);
    chk(seen[23:16], 8'h80);
  endtask

  task t_event;
    apb(1'b1, ETO_OFF_SEL, 32'h00043290);
    @(posedge clock) event_det <= 16'h0200;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (line_o[17] !== 1'b1 && n < 20);
    chk(n, 32'd8);
    chk(seen[20:16], 5'h02);
    @(posedge clock) event_det <= 16'h0000;
    repeat (9) @(negedge clock);
    chk(seen[20:16], 5'h00);
  endtask

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {break_hit, trace_hit, filter_act, prog_restart} = '0;
    event_det = 16'h0000;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_static;
    t_status;
    t_event;
    close_out;
  end
endmodule
